/* shared/pds_defs.svh */
// constants for the pump drive run supervisor
`ifndef PDS_DEFS_SVH
`define PDS_DEFS_SVH

// ************************************************************
// register map (byte addresses)
// ************************************************************
`define PDS_ADDR_W 12
`define PDS_CTRL_OFS 12'h000
`define PDS_STATUS_OFS 12'h004

// ************************************************************
// control fields and reset value
// ************************************************************
`define PDS_CTRL_W 8
`define PDS_CTRL_MODE_LSB 0
`define PDS_CTRL_R1ROLE_BIT 2
`define PDS_CTRL_R2ROLE_LSB 3
`define PDS_CTRL_R1NC_BIT 5
`define PDS_CTRL_R2NC_BIT 6
`define PDS_CTRL_RESEN_BIT 7
// auto-start mode, first relay as pressure trigger, second unused,
// both contacts closing, resonance watch on
`define PDS_CTRL_RST 8'h86

// ************************************************************
// status fields
// ************************************************************
`define PDS_STAT_STATE_LSB 0
`define PDS_STAT_HOLD_BIT 2
`define PDS_STAT_RESTRIP_BIT 3
`define PDS_STAT_EXTFLT_BIT 4

// ************************************************************
// timing
// ************************************************************
`define PDS_CLK_HZ 64'd100_000_000
`define PDS_START_HOLD_S 64'd3
`define PDS_RES_DWELL_S 64'd60
`define PDS_START_HOLD_CYC (`PDS_START_HOLD_S * `PDS_CLK_HZ)
`define PDS_RES_DWELL_CYC (`PDS_RES_DWELL_S * `PDS_CLK_HZ)

`endif

/* shared/pds_pkg.sv */
// types for the pump drive run supervisor
package pds_pkg;

    typedef enum logic [1:0] {
        PDS_MODE_PUSH,
        PDS_MODE_SWITCH,
        PDS_MODE_AUTO
    } pds_mode_t;

    typedef enum logic {
        PDS_R1_AT_SPEED,
        PDS_R1_PRESSURE
    } pds_r1_role_t;

    typedef enum logic [1:0] {
        PDS_R2_UNUSED,
        PDS_R2_FAULT,
        PDS_R2_BACKING
    } pds_r2_role_t;

    typedef enum logic [1:0] {
        PDS_ST_IDLE,
        PDS_ST_RUNUP,
        PDS_ST_ATSPEED,
        PDS_ST_FAULT
    } pds_state_t;

    // control register layout, msb first
    typedef struct packed {
        logic res_en;
        logic r2_nc;
        logic r1_nc;
        pds_r2_role_t r2_role;
        pds_r1_role_t r1_role;
        pds_mode_t mode;
    } pds_ctrl_t;

    // contact and drive feedback inputs
    typedef struct packed {
        logic start_closed;
        logic halt_closed;
        logic at_speed;
        logic in_band;
        logic current_below;
        logic drive_fault;
    } pds_sense_t;

endpackage : pds_pkg

/* rtl/pds_qual_timer.sv */
// qualification timer: flags a condition held for a number of cycles
`timescale 1ns/1ps
`include "pds_defs.svh"

module pds_qual_timer import pds_pkg::*; #(
    parameter longint unsigned CYCLES = `PDS_START_HOLD_CYC
) (
    input wire logic clk_sys, // system clock
    input wire logic reset,   // synchronous reset, high
    input wire logic ce,      // clock enable
    input wire logic cond,    // qualifying condition
    output logic done         // condition held for CYCLES
);
    localparam int W = $clog2(CYCLES + 64'd1);
    localparam logic [W-1:0] LIMIT = W'(CYCLES);

    logic [W-1:0] cnt_r;

    // count saturates so done stays while the condition holds
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_r <= '0;
        end else if (ce) begin
            if (!cond) begin
                cnt_r <= '0;
            end else if (cnt_r != LIMIT) begin
                cnt_r <= cnt_r + W'(1);
            end
        end
    end

    assign done = cond && (cnt_r == LIMIT);

    property p_restart;
        @(posedge clk_sys) disable iff (reset)
        (ce && !cond) |=> (cnt_r == '0) && !done;
    endproperty
    a_restart: assert property (p_restart)
        else $error("qualification count not restarted");

endmodule : pds_qual_timer

/* rtl/pds_supervisor.sv */
// pump drive run supervisor with apb control and status registers
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "pds_defs.svh"

module pds_supervisor import pds_pkg::*; #(
    parameter longint unsigned START_HOLD_CYC = `PDS_START_HOLD_CYC,
    parameter longint unsigned RES_DWELL_CYC = `PDS_RES_DWELL_CYC
) (
    input wire logic clk_sys,                // system clock, 100 MHz
    input wire logic reset,                  // synchronous reset, high
    input wire logic ce,                     // clock enable
    input wire logic psel,                   // apb select
    input wire logic penable,                // apb enable
    input wire logic pwrite,                 // apb write
    input wire logic [`PDS_ADDR_W-1:0] paddr, // apb address
    input wire logic [31:0] pwdata,          // apb write data
    output logic [31:0] prdata,              // apb read data
    output logic pready,                     // apb ready
    output logic pslverr,                    // apb error
    input wire pds_sense_t sense,            // contacts and drive feedback
    output logic drive_run,                  // drive enable
    output logic run_up_indicator,           // run-up lamp
    output logic at_speed_indicator,         // at-speed lamp
    output logic fault_indicator,            // fault lamp
    output logic first_relay,                // first relay coil
    output logic second_relay                // second relay coil
);

    // ********************************************************
    // state
    // ********************************************************
    pds_ctrl_t ctrl_r;
    pds_state_t st_r;
    pds_state_t st_nxt;
    logic auto_pend_r;
    logic res_trip_r;
    logic ext_flt_r;
    logic hold_done;
    logic res_done;
    logic running;
    logic stop_req;
    logic start_req;
    logic fault_evt;

    function automatic logic is_running(input pds_state_t s);
        return (s == PDS_ST_RUNUP) || (s == PDS_ST_ATSPEED);
    endfunction : is_running
    assign running = is_running(st_r);

    // ********************************************************
    // qualification timers
    // ********************************************************
    pds_qual_timer #(.CYCLES(START_HOLD_CYC)) u_hold (
        .clk_sys(clk_sys),
        .reset(reset),
        .ce(ce),
        .cond(sense.start_closed && ctrl_r.mode == PDS_MODE_PUSH),
        .done(hold_done)
    );

    // only the dwell while actually running counts
    pds_qual_timer #(.CYCLES(RES_DWELL_CYC)) u_dwell (
        .clk_sys(clk_sys),
        .reset(reset),
        .ce(ce),
        .cond(running && sense.in_band && ctrl_r.res_en),
        .done(res_done)
    );

    // ********************************************************
    // run sequencing
    // ********************************************************
    // auto mode has no stop: a run ends only on a fault or on power removal (reset)
    assign stop_req = (ctrl_r.mode != PDS_MODE_AUTO) &&
                      !sense.halt_closed;
    assign fault_evt = sense.drive_fault || res_done;

    always_comb begin
        start_req = 1'b0;
        case (ctrl_r.mode)
            PDS_MODE_PUSH: start_req = hold_done && sense.halt_closed;
            PDS_MODE_SWITCH: start_req = sense.halt_closed;
            PDS_MODE_AUTO: start_req = auto_pend_r;
            default: start_req = 1'b0;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            PDS_ST_IDLE: begin
                if (start_req) begin
                    st_nxt = PDS_ST_RUNUP;
                end
            end
            PDS_ST_RUNUP: begin
                if (fault_evt) begin
                    st_nxt = PDS_ST_FAULT;
                end else if (stop_req) begin
                    st_nxt = PDS_ST_IDLE;
                end else if (sense.at_speed) begin
                    st_nxt = PDS_ST_ATSPEED;
                end
            end
            PDS_ST_ATSPEED: begin
                if (fault_evt) begin
                    st_nxt = PDS_ST_FAULT;
                end else if (stop_req) begin
                    st_nxt = PDS_ST_IDLE;
                end
            end
            PDS_ST_FAULT: begin
                // a fresh fault in the same cycle keeps the latch set
                if (stop_req && !fault_evt) begin
                    st_nxt = PDS_ST_IDLE;
                end
            end
            default: st_nxt = PDS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r <= PDS_ST_IDLE;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // armed once per power-up, so auto mode never restarts after a stop
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            auto_pend_r <= 1'b1;
        end else if (ce && (st_r != PDS_ST_IDLE)) begin
            auto_pend_r <= 1'b0;
        end
    end

    // fault cause flags, cleared only on the way out of the fault state
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            res_trip_r <= 1'b0;
            ext_flt_r <= 1'b0;
        end else if (ce) begin
            if (running && res_done) begin
                res_trip_r <= 1'b1;
            end else if (st_r == PDS_ST_FAULT && st_nxt == PDS_ST_IDLE) begin
                res_trip_r <= 1'b0;
            end
            if (running && sense.drive_fault) begin
                ext_flt_r <= 1'b1;
            end else if (st_r == PDS_ST_FAULT && st_nxt == PDS_ST_IDLE) begin
                ext_flt_r <= 1'b0;
            end
        end
    end

    // ********************************************************
    // indicators and relays
    // ********************************************************
    logic r1_act;
    logic r2_act;

    always_comb begin
        if (ctrl_r.r1_role == PDS_R1_PRESSURE) begin
            r1_act = running && sense.current_below;
        end else begin
            r1_act = (st_r == PDS_ST_ATSPEED);
        end
        case (ctrl_r.r2_role)
            PDS_R2_FAULT: r2_act = (st_r == PDS_ST_FAULT);
            PDS_R2_BACKING: r2_act = (st_r != PDS_ST_IDLE);
            default: r2_act = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            drive_run <= 1'b0;
            run_up_indicator <= 1'b0;
            at_speed_indicator <= 1'b0;
            fault_indicator <= 1'b0;
            first_relay <= 1'b0;
            second_relay <= 1'b0;
        end else if (ce) begin
            drive_run <= running;
            run_up_indicator <= (st_r == PDS_ST_RUNUP);
            at_speed_indicator <= (st_r == PDS_ST_ATSPEED);
            fault_indicator <= (st_r == PDS_ST_FAULT);
            first_relay <= r1_act ^ ctrl_r.r1_nc;
            // an unused relay stays released whatever its sense
            second_relay <= (ctrl_r.r2_role != PDS_R2_UNUSED) &&
                            (r2_act ^ ctrl_r.r2_nc);
        end
    end

    // ********************************************************
    // apb slave
    // ********************************************************
    logic hit_ctrl;
    logic hit_stat;

    assign hit_ctrl = (paddr == `PDS_CTRL_OFS);
    assign hit_stat = (paddr == `PDS_STATUS_OFS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit_ctrl || hit_stat);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_r <= pds_ctrl_t'(`PDS_CTRL_RST);
        end else if (ce && psel && penable && pwrite && hit_ctrl) begin
            ctrl_r <= pds_ctrl_t'(pwdata[`PDS_CTRL_W-1:0]);
        end
    end

    // read data captured in the setup cycle, ready in the access cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata <= 32'h0000_0000;
            if (hit_ctrl) begin
                prdata[`PDS_CTRL_W-1:0] <= ctrl_r;
            end else if (hit_stat) begin
                prdata[`PDS_STAT_STATE_LSB+:2] <= st_r;
                prdata[`PDS_STAT_HOLD_BIT] <= hold_done;
                prdata[`PDS_STAT_RESTRIP_BIT] <= res_trip_r;
                prdata[`PDS_STAT_EXTFLT_BIT] <= ext_flt_r;
            end
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_push_ready;
        ce && st_r == PDS_ST_IDLE && ctrl_r.mode == PDS_MODE_PUSH;
    endsequence
    sequence s_run_stop;
        ce && running && !fault_evt && !sense.halt_closed;
    endsequence

    property p_push_start;
        s_push_ready ##0 (hold_done && sense.halt_closed) |=>
            st_r == PDS_ST_RUNUP ##1 drive_run;
    endproperty
    a_push_start: assert property (p_push_start)
        else $error("pushbutton start not taken");

    property p_push_nohold;
        s_push_ready ##0 !hold_done |=> st_r == PDS_ST_IDLE;
    endproperty
    a_push_nohold: assert property (p_push_nohold)
        else $error("started without a qualified hold");

    property p_push_stop;
        s_run_stop ##0 ctrl_r.mode == PDS_MODE_PUSH |=>
            st_r == PDS_ST_IDLE ##1 !drive_run;
    endproperty
    a_push_stop: assert property (p_push_stop)
        else $error("open stop loop did not stop the pump");

    property p_switch_run;
        ce && st_r == PDS_ST_IDLE && ctrl_r.mode == PDS_MODE_SWITCH &&
        sense.halt_closed |=> st_r == PDS_ST_RUNUP;
    endproperty
    a_switch_run: assert property (p_switch_run)
        else $error("switch mode did not start");

    property p_auto_start;
        ce && st_r == PDS_ST_IDLE && ctrl_r.mode == PDS_MODE_AUTO &&
        auto_pend_r |=> st_r == PDS_ST_RUNUP ##1 run_up_indicator;
    endproperty
    a_auto_start: assert property (p_auto_start)
        else $error("auto start missing");

    property p_lamps;
        ce && st_r == PDS_ST_ATSPEED |=>
            at_speed_indicator && !run_up_indicator;
    endproperty
    a_lamps: assert property (p_lamps)
        else $error("indicators wrong at speed");

    property p_fault_hold;
        ce && st_r == PDS_ST_FAULT && !stop_req |=> st_r == PDS_ST_FAULT;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault released without a stop");

    property p_pressure;
        ce && ctrl_r.r1_role == PDS_R1_PRESSURE && running &&
        sense.current_below |=> first_relay == !$past(ctrl_r.r1_nc);
    endproperty
    a_pressure: assert property (p_pressure)
        else $error("pressure relay not active below limit");

    property p_resonance;
        ce && running && res_done |=> st_r == PDS_ST_FAULT ##1
            fault_indicator && !drive_run;
    endproperty
    a_resonance: assert property (p_resonance)
        else $error("resonance dwell did not shut down");

    property p_backing;
        ce && ctrl_r.r2_role == PDS_R2_BACKING && !ctrl_r.r2_nc &&
        st_r == PDS_ST_IDLE |=> !second_relay;
    endproperty
    a_backing: assert property (p_backing)
        else $error("backing relay active while stopped");

    property p_fault_relay;
        ce && ctrl_r.r2_role == PDS_R2_FAULT && ctrl_r.r2_nc &&
        st_r == PDS_ST_FAULT |=> !second_relay;
    endproperty
    a_fault_relay: assert property (p_fault_relay)
        else $error("inverted fault relay wrong");

endmodule : pds_supervisor

/* verification/pds_pump_model.sv */
// behavioural pump drive and contact wiring beside the supervisor
`timescale 1ns/1ps

module pds_pump_model import pds_pkg::*; #(
    parameter int AT_LVL = 30,
    parameter int BAND_LO = 10,
    parameter int BAND_HI = 20
) (
    input wire logic clk_sys,     // system clock
    input wire logic reset,       // power-up reset
    input wire logic drive_run,   // drive enable from the supervisor
    input wire logic start_cmd,   // start contact closed
    input wire logic halt_cmd,    // stop loop closed
    input wire logic low_cur_cmd, // link current below limit
    input wire logic fault_cmd,   // drive fault request
    input wire logic stall_cmd,   // hold speed inside resonance band
    output pds_sense_t sense      // contacts and drive feedback
);
    int speed_r;

    // ************************************************************
    // rotor speed
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            speed_r <= 0;
        end else if (drive_run) begin
            // a stall pins the rotor just inside the band to provoke a dwell trip
            if (!(stall_cmd && speed_r >= BAND_LO + 2) && speed_r < 40) begin
                speed_r <= speed_r + 1;
            end
        end else if (speed_r > 0) begin
            speed_r <= speed_r - 1;
        end
    end

    // ************************************************************
    // feedback
    // ************************************************************
    always_comb begin
        sense.start_closed = start_cmd;
        sense.halt_closed = halt_cmd;
        sense.at_speed = speed_r >= AT_LVL;
        sense.in_band = speed_r >= BAND_LO && speed_r <= BAND_HI;
        sense.current_below = low_cur_cmd;
        // a stopped drive cannot report a fault of its own
        sense.drive_fault = fault_cmd && drive_run;
    end
endmodule : pds_pump_model

/* verification/testbench.sv */
// self-checking bench for the pump drive run supervisor
`timescale 1ns/1ps
`include "pds_defs.svh"

module testbench;
    localparam int HOLD = 20;
    localparam int DWELL = 50;
    localparam int LIMIT = 20000;
    typedef struct {logic [7:0] ctrl; logic r1; logic r2;} pds_row_t;
    logic clk_sys, reset, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [`PDS_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic drive_run, run_up_indicator, at_speed_indicator, fault_indicator;
    logic first_relay, second_relay;
    logic start_cmd, halt_cmd, low_cur_cmd, fault_cmd, stall_cmd;
    pds_pkg::pds_sense_t sense;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    pds_row_t rows [7] = '{'{8'h82, 1, 0}, '{8'ha2, 0, 0}, '{8'h8e, 1, 0},
        '{8'hce, 1, 1}, '{8'h96, 1, 1}, '{8'hd6, 1, 0}, '{8'hc6, 1, 0}};

    pds_supervisor #(.START_HOLD_CYC(HOLD), .RES_DWELL_CYC(DWELL))
        u_pds_supervisor (.clk_sys(clk_sys), .reset(reset), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sense(sense), .drive_run(drive_run),
        .run_up_indicator(run_up_indicator),
        .at_speed_indicator(at_speed_indicator),
        .fault_indicator(fault_indicator), .first_relay(first_relay),
        .second_relay(second_relay));

    pds_pump_model u_pds_pump_model (.clk_sys(clk_sys), .reset(reset),
        .drive_run(drive_run), .start_cmd(start_cmd), .halt_cmd(halt_cmd),
        .low_cur_cmd(low_cur_cmd), .fault_cmd(fault_cmd),
        .stall_cmd(stall_cmd), .sense(sense));

    // ************************************************************
    // clock and hang guard
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            results();
        end
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // called just after a rising edge; leaves one idle edge behind
    task automatic apb(input logic wr, input logic [`PDS_ADDR_W-1:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic done_test(input string name);
        $display("test %s finished", name);
    endtask : done_test

    task automatic results;
        $display("compared %0d mismatched %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        ce = 1'b1;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        start_cmd = 1'b0;
        halt_cmd = 1'b0;
        low_cur_cmd = 1'b1;
        fault_cmd = 1'b0;
        stall_cmd = 1'b0;
        cyc(8);
        chk("outputs in reset", 6'h0, {drive_run, run_up_indicator,
            at_speed_indicator, fault_indicator, first_relay, second_relay});
        reset <= 1'b0;
        @(posedge clk_sys);
        apb(1'b0, `PDS_CTRL_OFS, 32'h0);
        chk("ctrl reset", 32'h86, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        chk("run-up lamp", 1'b1, run_up_indicator);
        chk("drive with halt open", 1'b1, drive_run);
        cyc(40);
        chk("at-speed lamp", 2'b10, {at_speed_indicator,
            run_up_indicator});
        apb(1'b1, `PDS_STATUS_OFS, 32'h0);
        apb(1'b0, `PDS_STATUS_OFS, 32'h0);
        chk("status state", 2'h2, rd[1:0]);
        chk("pressure relay", 1'b1, first_relay);
        low_cur_cmd <= 1'b0;
        cyc(4);
        chk("pressure relay", 1'b0, first_relay);
        low_cur_cmd <= 1'b1;
        done_test("autostart");
        foreach (rows[i]) begin
            apb(1'b1, `PDS_CTRL_OFS, {24'h0, rows[i].ctrl});
            cyc(3);
            chk("first_relay", rows[i].r1, first_relay);
            chk("second_relay", rows[i].r2, second_relay);
        end
        done_test("relay roles");
        // switch mode with halt open must stop the running pump
        apb(1'b1, `PDS_CTRL_OFS, 32'h91);
        cyc(4);
        chk("switch stop", 2'b00, {drive_run, second_relay});
        halt_cmd <= 1'b1;
        cyc(4);
        chk("switch run", 2'b11, {drive_run, second_relay});
        // a low enable must freeze the stop as well
        ce <= 1'b0;
        halt_cmd <= 1'b0;
        cyc(4);
        chk("ce freeze", 2'b11, {drive_run, second_relay});
        ce <= 1'b1;
        cyc(4);
        chk("switch stop", 2'b00, {drive_run, second_relay});
        done_test("switch");
        apb(1'b1, `PDS_CTRL_OFS, 32'h88);
        halt_cmd <= 1'b1;
        start_cmd <= 1'b1;
        cyc(HOLD - 1);
        start_cmd <= 1'b0;
        cyc(1);
        start_cmd <= 1'b1;
        cyc(HOLD - 1);
        chk("hold restart", 1'b0, drive_run);
        cyc(6);
        chk("hold start", 1'b1, drive_run);
        start_cmd <= 1'b0;
        fault_cmd <= 1'b1;
        cyc(1);
        fault_cmd <= 1'b0;
        cyc(3);
        chk("fault out", 3'b110, {fault_indicator, second_relay,
            drive_run});
        start_cmd <= 1'b1;
        cyc(HOLD + 6);
        chk("fault restart", 1'b0, drive_run);
        apb(1'b0, `PDS_STATUS_OFS, 32'h0);
        chk("fault cause", 5'h17, rd[4:0]);
        start_cmd <= 1'b0;
        halt_cmd <= 1'b0;
        cyc(4);
        chk("fault clear", 2'b00, {fault_indicator, second_relay});
        halt_cmd <= 1'b1;
        start_cmd <= 1'b1;
        cyc(HOLD + 6);
        chk("fresh start", 1'b1, drive_run);
        start_cmd <= 1'b0;
        halt_cmd <= 1'b0;
        cyc(4);
        chk("loop open", 1'b0, drive_run);
        done_test("pushbutton and fault");
        apb(1'b1, `PDS_CTRL_OFS, 32'hc9);
        stall_cmd <= 1'b1;
        halt_cmd <= 1'b1;
        cyc(DWELL - 5);
        chk("dwell early", 1'b0, fault_indicator);
        chk("inverted relay", 1'b1, second_relay);
        cyc(DWELL);
        chk("dwell trip", 2'b10, {fault_indicator, drive_run});
        chk("fault relay off", 1'b0, second_relay);
        apb(1'b0, `PDS_STATUS_OFS, 32'h0);
        chk("trip cause", 5'h0b, rd[4:0]);
        halt_cmd <= 1'b0;
        cyc(4);
        apb(1'b1, `PDS_CTRL_OFS, 32'h01);
        halt_cmd <= 1'b1;
        cyc(2 * DWELL);
        chk("watch off", 2'b01, {fault_indicator, drive_run});
        halt_cmd <= 1'b0;
        stall_cmd <= 1'b0;
        done_test("resonance");
        // power cycle: auto start again, a fault then needs another one
        reset <= 1'b1;
        cyc(2);
        reset <= 1'b0;
        cyc(1);
        chk("reset outputs", 2'b00, {drive_run, fault_indicator});
        fault_cmd <= 1'b1;
        cyc(3);
        fault_cmd <= 1'b0;
        cyc(8);
        chk("auto fault held", 2'b10, {fault_indicator, drive_run});
        reset <= 1'b1;
        cyc(2);
        reset <= 1'b0;
        cyc(4);
        chk("cycled", 2'b01, {fault_indicator, drive_run});
        done_test("power cycle");
        results();
    end
endmodule : testbench
